/* File: verilog/ddr3_cmd_pin_if.sv */
// command, address and control pin front end of the memory device
module ddr3_cmd_pin_if (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire ddr3_cmd_pkg::ca_bus_t ca_pins,
  input wire logic dm_pin,
  input wire logic [ddr3_cmd_pkg::DQ_W-1:0] wdata_pin,
  input wire logic wbeat_pin,
  input wire logic x8_cfg,
  output ddr3_cmd_pkg::dec_cmd_t cmd_out,
  output logic [ddr3_cmd_pkg::NBANK-1:0] open_banks,
  output ddr3_cmd_pkg::pwr_t pwr_state,
  output logic clocks_enabled,
  output logic odt_active,
  output logic tdqs_enabled,
  output ddr3_cmd_pkg::beat_t wbeat_out,
  output logic [ddr3_cmd_pkg::ROW_W-1:0] mr0_reg,
  output logic [ddr3_cmd_pkg::ROW_W-1:0] mr1_reg,
  output logic [ddr3_cmd_pkg::ROW_W-1:0] mr2_reg,
  output logic [ddr3_cmd_pkg::ROW_W-1:0] mr3_reg
);
  // ------------------------------------------------------------
  // reset and pin synchronisers
  // ------------------------------------------------------------
  logic rst_pin;
  logic rst;
  ddr3_async_reset_sync u_rst (
    .clk(clk),
    .reset_pin_n(reset_pin_n),
    .rst_core(rst_pin)
  );
  assign rst = srst | rst_pin;

  ddr3_cmd_pkg::ca_bus_t ca_meta_reg;
  ddr3_cmd_pkg::ca_bus_t ca_reg;
  logic dm_meta_reg;
  logic dm_reg;
  logic [ddr3_cmd_pkg::DQ_W-1:0] wd_meta_reg;
  logic [ddr3_cmd_pkg::DQ_W-1:0] wd_reg;
  logic wb_meta_reg;
  logic wb_reg;
  logic cke_async_reg;

  always_ff @(posedge clk) begin
    ca_meta_reg <= ca_pins;
    ca_reg <= ca_meta_reg;
    dm_meta_reg <= dm_pin;
    dm_reg <= dm_meta_reg;
    wd_meta_reg <= wdata_pin;
    wd_reg <= wd_meta_reg;
    wb_meta_reg <= wbeat_pin;
    wb_reg <= wb_meta_reg;
  end

  // cke delayed one more stage so its falling edge is seen and commands need two high samples
  always_ff @(posedge clk) begin
    cke_async_reg <= ca_reg.cke;
  end

  // ------------------------------------------------------------
  // input buffer gating
  // ------------------------------------------------------------
  ddr3_cmd_pkg::pwr_t pwr_reg;
  ddr3_cmd_pkg::pwr_t pwr_next;
  logic in_pd;
  logic in_sr;
  logic cmd_buf_on;
  logic odt_buf_on;
  assign in_pd = (pwr_reg == ddr3_cmd_pkg::PW_POWERDOWN);
  assign in_sr = (pwr_reg == ddr3_cmd_pkg::PW_SELFREF);
  assign cmd_buf_on = !in_pd && !in_sr;
  assign odt_buf_on = !in_sr;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  function automatic ddr3_cmd_pkg::cmd_t decode(input ddr3_cmd_pkg::ca_bus_t c);
    decode = ddr3_cmd_pkg::cmd_t'({c.ras_n, c.cas_n, c.we_n});
  endfunction

  logic [ddr3_cmd_pkg::ROW_W-1:0] mr0_next;
  logic [ddr3_cmd_pkg::ROW_W-1:0] mr1_next;
  logic [ddr3_cmd_pkg::ROW_W-1:0] mr2_next;
  logic [ddr3_cmd_pkg::ROW_W-1:0] mr3_next;
  logic selected;
  ddr3_cmd_pkg::cmd_t cmd_now;
  logic cmd_take;
  logic is_act;
  logic is_rw;
  logic is_pre;
  logic is_ref;
  logic is_lmr;
  logic otf_on;
  logic a10;
  logic [ddr3_cmd_pkg::NBANK-1:0] bank_onehot;
  logic [ddr3_cmd_pkg::NBANK-1:0] pre_mask;
  logic [1:0] mr_sel;

  assign selected = !ca_reg.cs_n;
  assign cmd_now = decode(ca_reg);
  assign cmd_take = selected && cmd_buf_on && ca_reg.cke && cke_async_reg;
  assign is_act = cmd_take && (cmd_now == ddr3_cmd_pkg::CMD_ACTIVATE);
  assign is_rw = cmd_take && ((cmd_now == ddr3_cmd_pkg::CMD_READ) ||
                 (cmd_now == ddr3_cmd_pkg::CMD_WRITE));
  assign is_pre = cmd_take && (cmd_now == ddr3_cmd_pkg::CMD_PRECHARGE);
  assign is_ref = cmd_take && (cmd_now == ddr3_cmd_pkg::CMD_REFRESH);
  assign is_lmr = cmd_take && (cmd_now == ddr3_cmd_pkg::CMD_LOAD_MODE);
  assign a10 = ca_reg.addr[ddr3_cmd_pkg::AP_BIT];
  assign bank_onehot = ddr3_cmd_pkg::NBANK'(1) << ca_reg.ba;
  assign pre_mask = a10 ? ddr3_cmd_pkg::BANKS_ALL : bank_onehot;
  // chop only when otf mode set
  assign otf_on = (mr0_reg[ddr3_cmd_pkg::MR0_BL_LO +: 2] == ddr3_cmd_pkg::BL_OTF);
  assign mr_sel = ca_reg.ba[1:0];

  ddr3_cmd_pkg::dec_cmd_t cmd_next;
  always_comb begin
    cmd_next = '0;
    cmd_next.valid = cmd_take;
    cmd_next.cmd = cmd_take ? cmd_now : ddr3_cmd_pkg::CMD_NOP;
    cmd_next.bank = ca_reg.ba;
    // row on activate, column on access
    cmd_next.row = is_act ? ca_reg.addr : '0;
    cmd_next.col = is_rw ? ca_reg.addr[ddr3_cmd_pkg::COL_W-1:0] : '0;
    cmd_next.auto_pre = is_rw && a10;
    cmd_next.chop4 = is_rw && otf_on && !ca_reg.addr[ddr3_cmd_pkg::BC_BIT];
    cmd_next.pre_mask = is_pre ? pre_mask : '0;
  end

  assign mr0_next = (is_lmr && mr_sel == ddr3_cmd_pkg::MR_SEL_0) ? ca_reg.addr : mr0_reg;
  assign mr1_next = (is_lmr && mr_sel == ddr3_cmd_pkg::MR_SEL_1) ? ca_reg.addr : mr1_reg;
  assign mr2_next = (is_lmr && mr_sel == ddr3_cmd_pkg::MR_SEL_2) ? ca_reg.addr : mr2_reg;
  assign mr3_next = (is_lmr && mr_sel == ddr3_cmd_pkg::MR_SEL_3) ? ca_reg.addr : mr3_reg;

  // ------------------------------------------------------------
  // bank tracking
  // ------------------------------------------------------------
  logic [ddr3_cmd_pkg::NBANK-1:0] banks_reg;
  logic [ddr3_cmd_pkg::NBANK-1:0] banks_next;
  // auto precharge closes the bank at once here; burst timing is out of scope
  assign banks_next = is_act ? (banks_reg | bank_onehot) :
                      is_pre ? (banks_reg & ~pre_mask) :
                      (is_rw && a10) ? (banks_reg & ~bank_onehot) : banks_reg;

  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  logic all_idle;
  assign all_idle = (banks_reg == ddr3_cmd_pkg::BANKS_CLOSED);

  // self refresh entry is a refresh issued with cke going low, banks idle
  function automatic logic is_ref_pend(input logic sel, input ddr3_cmd_pkg::cmd_t c,
                                       input logic idle);
    is_ref_pend = sel && idle && (c == ddr3_cmd_pkg::CMD_REFRESH);
  endfunction

  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      ddr3_cmd_pkg::PW_ACTIVE: begin
        if (!ca_reg.cke && cke_async_reg) begin
          pwr_next = (is_ref_pend(selected, cmd_now, all_idle)) ?
                     ddr3_cmd_pkg::PW_SELFREF : ddr3_cmd_pkg::PW_POWERDOWN;
        end
      end
      ddr3_cmd_pkg::PW_POWERDOWN: begin
        if (ca_reg.cke) begin
          pwr_next = ddr3_cmd_pkg::PW_ACTIVE;
        end
      end
      ddr3_cmd_pkg::PW_SELFREF: begin
        // exit on one sample, no two-edge qualification
        // first sync stage is never read by logic, so no metastability hazard
        if (ca_reg.cke) begin
          pwr_next = ddr3_cmd_pkg::PW_ACTIVE;
        end
      end
      default: pwr_next = ddr3_cmd_pkg::PW_ACTIVE;
    endcase
  end

  // ------------------------------------------------------------
  // termination and data mask
  // ------------------------------------------------------------
  logic rtt_on;
  logic tdqs_on;
  logic odt_next;
  logic [ddr3_cmd_pkg::DQ_W-1:0] wd_latched;
  logic wbeat_keep;
  assign rtt_on = mr1_reg[ddr3_cmd_pkg::MR1_RTT0] | mr1_reg[ddr3_cmd_pkg::MR1_RTT1] |
                  mr1_reg[ddr3_cmd_pkg::MR1_RTT2];
  assign odt_next = rtt_on && odt_buf_on && ca_reg.odt;
  assign tdqs_on = x8_cfg && mr1_reg[ddr3_cmd_pkg::MR1_TDQS];
  assign wbeat_keep = wb_reg && cmd_buf_on && (tdqs_on || !dm_reg);
  assign wd_latched = wd_reg;

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  // pin reset folded into rst
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_reg <= ddr3_cmd_pkg::PW_ACTIVE;
      banks_reg <= ddr3_cmd_pkg::BANKS_CLOSED;
      mr0_reg <= ddr3_cmd_pkg::MR_RESET;
      mr1_reg <= ddr3_cmd_pkg::MR_RESET;
      mr2_reg <= ddr3_cmd_pkg::MR_RESET;
      mr3_reg <= ddr3_cmd_pkg::MR_RESET;
    end else begin
      pwr_reg <= pwr_next;
      banks_reg <= banks_next;
      mr0_reg <= mr0_next;
      mr1_reg <= mr1_next;
      mr2_reg <= mr2_next;
      mr3_reg <= mr3_next;
    end
  end

  // output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_out <= '0;
      odt_active <= 1'b0;
      tdqs_enabled <= 1'b0;
      wbeat_out <= '0;
      clocks_enabled <= 1'b0;
    end else begin
      cmd_out <= cmd_next;
      odt_active <= odt_next;
      tdqs_enabled <= tdqs_on;
      wbeat_out.valid <= wbeat_keep;
      wbeat_out.data <= wbeat_keep ? wd_latched : '0;
      clocks_enabled <= (pwr_next == ddr3_cmd_pkg::PW_ACTIVE);
    end
  end

  assign open_banks = banks_reg;
  assign pwr_state = pwr_reg;
endmodule

/* File: verilog/ddr3_cmd_pkg.sv */
// constants and types for the command pin front end
// Functional notes
// - all command, control and address inputs are registered on rising clock.
// - activate takes row address; read/write take column and auto-precharge bit.
// - precharge closes one bank when bit ten low, all banks when high.
// - with on-the-fly chop enabled, bit twelve picks full eight or chopped four.
// - bank inputs choose target bank of activate, read, write, precharge.
// - on load mode, bank inputs choose which of four mode registers.
// - on load mode, address inputs carry the operation code written.
// - decoder works only when chip select registered low; high masks all.
// - command is decoded from select, row strobe, column strobe, write enable.
// - clock enable high runs circuitry, low enters power-down or self refresh.
// - clock enable synchronous for entries and power-down exit; async self refresh exit (here sampled through the synchroniser).
// - power-down keeps clock, enable, reset, termination; self refresh only enable, reset (clocks_enabled drops in power-down too).
// - write beats with mask sampled high are discarded.
// - on x8 with termination strobe enabled, masking is unavailable.
// - termination pin high enables on-die termination, low disables it.
// - termination disabled by load mode makes the termination pin ignored.
// - reset pin is active low, asserted and released without the clock (here release takes two clock edges through the synchroniser).
package ddr3_cmd_pkg;
  localparam int ROW_W = 16;
  localparam int BANK_W = 3;
  localparam int NBANK = 8;
  localparam int COL_W = 10;
  localparam int DQ_W = 8;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // mode register field positions
  localparam int MR0_BL_LO = 0;
  localparam int MR1_RTT0 = 2;
  localparam int MR1_RTT1 = 6;
  localparam int MR1_RTT2 = 9;
  localparam int MR1_TDQS = 11;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [ROW_W-1:0] MR_RESET = 16'h0000;
  localparam logic [NBANK-1:0] BANKS_CLOSED = 8'h00;
  localparam logic [NBANK-1:0] BANKS_ALL = 8'hFF;
  localparam logic [1:0] MR_SEL_0 = 2'h0;
  localparam logic [1:0] MR_SEL_1 = 2'h1;
  localparam logic [1:0] MR_SEL_2 = 2'h2;
  localparam logic [1:0] MR_SEL_3 = 2'h3;

  // {ras_n, cas_n, we_n} with chip select low
  typedef enum logic [2:0] {
    CMD_LOAD_MODE = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ACTIVATE = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_ZQ_CAL = 3'h6,
    CMD_NOP = 3'h7
  } cmd_t;

  // power states, gray along idle -> power-down -> self refresh
  typedef enum logic [1:0] {
    PW_ACTIVE = 2'h0,
    PW_POWERDOWN = 2'h1,
    PW_SELFREF = 2'h3
  } pwr_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic odt;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] addr;
  } ca_bus_t;

  typedef struct packed {
    logic valid;
    cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic auto_pre;
    logic chop4;
    logic [NBANK-1:0] pre_mask;
  } dec_cmd_t;

  typedef struct packed {
    logic valid;
    logic [DQ_W-1:0] data;
  } beat_t;
endpackage

/* File: verilog/ddr3_async_reset_sync.sv */
// reset pin conditioner: async assert, two-stage release
module ddr3_async_reset_sync (
  input wire logic clk,
  input wire logic reset_pin_n,
  output logic rst_core
);
  logic meta_reg;
  logic hold_reg;

  always_ff @(posedge clk or negedge reset_pin_n) begin
    if (!reset_pin_n) begin
      meta_reg <= 1'b1;
      hold_reg <= 1'b1;
    end else begin
      meta_reg <= 1'b0;
      hold_reg <= meta_reg;
    end
  end
  assign rst_core = hold_reg;
endmodule

/* File: test/ddr3_cmd_pin_monitor.sv */
// concurrent checks on the command pin front end ports
module ddr3_cmd_pin_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire ddr3_cmd_pkg::ca_bus_t ca_pins,
  input wire logic dm_pin,
  input wire logic [ddr3_cmd_pkg::DQ_W-1:0] wdata_pin,
  input wire ddr3_cmd_pkg::dec_cmd_t cmd_out,
  input wire logic [ddr3_cmd_pkg::NBANK-1:0] open_banks,
  input wire ddr3_cmd_pkg::pwr_t pwr_state,
  input wire logic odt_active,
  input wire logic tdqs_enabled,
  input wire ddr3_cmd_pkg::beat_t wbeat_out,
  input wire logic [ddr3_cmd_pkg::ROW_W-1:0] mr0_reg,
  input wire logic [ddr3_cmd_pkg::ROW_W-1:0] mr1_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // decode helpers, pins reach cmd_out 3 edges later
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !reset_pin_n);
  wire logic [2:0] code = {ca_pins.ras_n, ca_pins.cas_n, ca_pins.we_n};
  wire logic vact = cmd_out.valid && cmd_out.cmd == ddr3_cmd_pkg::CMD_ACTIVATE;
  wire logic vpre = cmd_out.valid && cmd_out.cmd == ddr3_cmd_pkg::CMD_PRECHARGE;
  wire logic vrw = cmd_out.valid && (cmd_out.cmd == ddr3_cmd_pkg::CMD_READ ||
                                     cmd_out.cmd == ddr3_cmd_pkg::CMD_WRITE);

  cs_masked_a: assert property ($past(ca_pins.cs_n, 3) |-> !cmd_out.valid)
    else $error("command taken while deselected");
  cmd_code_a: assert property (cmd_out.valid |-> cmd_out.cmd == $past(code, 3))
    else $error("decoded command differs from pins");
  bank_sel_a: assert property (vact || vrw || vpre |->
    cmd_out.bank == $past(ca_pins.ba, 3)) else $error("wrong target bank");
  row_take_a: assert property (vact |-> cmd_out.row == $past(ca_pins.addr, 3))
    else $error("row address not taken");
  col_take_a: assert property (vrw |->
    {cmd_out.auto_pre, cmd_out.col} == $past(ca_pins.addr[10:0], 3)) else $error("bad column");
  pre_mask_a: assert property (vpre |-> cmd_out.pre_mask ==
    ($past(ca_pins.addr[10], 3) ? ddr3_cmd_pkg::BANKS_ALL : 8'h01 << $past(ca_pins.ba, 3)))
    else $error("bad precharge mask");
  chop_sel_a: assert property (vrw |-> cmd_out.chop4 ==
    ($past(mr0_reg[1:0]) == ddr3_cmd_pkg::BL_OTF && !$past(ca_pins.addr[12], 3)))
    else $error("bad burst chop");
  mask_drop_a: assert property (wbeat_out.valid && !tdqs_enabled |->
    !$past(dm_pin, 3) && wbeat_out.data == $past(wdata_pin, 3)) else $error("masked beat kept");
  odt_mode_a: assert property (odt_active |->
    $past(mr1_reg[2] || mr1_reg[6] || mr1_reg[9])) else $error("termination while disabled");
  reset_clear_a: assert property (disable iff (srst) !reset_pin_n && $past(!reset_pin_n) |->
    !cmd_out.valid && open_banks == ddr3_cmd_pkg::BANKS_CLOSED && !odt_active)
    else $error("state kept under reset pin");
endmodule

/* File: test/ddr3_ctrl_model.sv */
// memory controller model driving the command and address pins
module ddr3_ctrl_model (
  input wire logic clk,
  output ddr3_cmd_pkg::ca_bus_t ca_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // pin driving
  // ----------------------------------------
  // idle: deselected, clock enabled, termination off
  initial begin
    ca_pins = '0;
    ca_pins.cs_n = 1'b1;
    ca_pins.cke = 1'b1;
  end

  task automatic issue(input logic sel_n, input ddr3_cmd_pkg::cmd_t c, input logic [2:0] b,
                       input logic [15:0] a, input logic ke);
    @(posedge clk);
    ca_pins.cs_n <= sel_n;
    {ca_pins.ras_n, ca_pins.cas_n, ca_pins.we_n} <= c;
    ca_pins.cke <= ke;
    ca_pins.ba <= b;
    // bit ten picks one or all
    ca_pins.addr <= a;
    @(posedge clk);
    ca_pins.cs_n <= 1'b1;
    // inverse on stale lines so a late sample never matches by luck
    ca_pins.ba <= ~b;
    ca_pins.addr <= ~a;
  endtask

  task automatic set_ctl(input logic ke, input logic od);
    @(posedge clk);
    ca_pins.cke <= ke;
    ca_pins.odt <= od;
  endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the command pin front end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic dm_pin = 1'b0;
  logic wbeat_pin = 1'b0;
  logic [7:0] wdata_pin = 8'h00;
  ddr3_cmd_pkg::ca_bus_t ca_pins;
  ddr3_cmd_pkg::dec_cmd_t cmd_out;
  ddr3_cmd_pkg::dec_cmd_t got;
  ddr3_cmd_pkg::pwr_t pwr_state;
  ddr3_cmd_pkg::beat_t wbeat_out;
  logic [7:0] open_banks;
  logic clocks_enabled, odt_active, tdqs_enabled;
  logic [15:0] mr0_reg, mr1_reg, mr2_reg, mr3_reg;
  int fail_count = 0;
  int n_tests = 0;

  ddr3_ctrl_model ctrl (.clk(clk), .ca_pins(ca_pins));
  ddr3_cmd_pin_if DUT (.clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .ca_pins(ca_pins),
    .dm_pin(dm_pin), .wdata_pin(wdata_pin), .wbeat_pin(wbeat_pin), .x8_cfg(1'b1),
    .cmd_out(cmd_out), .open_banks(open_banks), .pwr_state(pwr_state),
    .clocks_enabled(clocks_enabled), .odt_active(odt_active), .tdqs_enabled(tdqs_enabled),
    .wbeat_out(wbeat_out), .mr0_reg(mr0_reg), .mr1_reg(mr1_reg), .mr2_reg(mr2_reg),
    .mr3_reg(mr3_reg));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial forever #20 clk = ~clk;

  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // one command, then a bounded look for its decoded pulse
  task automatic run(input logic s, input ddr3_cmd_pkg::cmd_t c, input logic [2:0] b,
                     input logic [15:0] a, input logic k, input logic e);
    logic seen;
    seen = 1'b0;
    ctrl.issue(s, c, b, a, k);
    repeat (5) begin
      @(posedge clk);
      #1;
      if (cmd_out.valid === 1'b1) begin
        seen = 1'b1;
        got = cmd_out;
      end
    end
    chk(seen === e, "command taken or refused wrongly");
  endtask

  task automatic wait_pwr(input ddr3_cmd_pkg::pwr_t p);
    for (int i = 0; i < 10 && pwr_state !== p; i++) begin
      @(posedge clk);
      #1;
    end
    chk(pwr_state === p, "power state");
    chk(clocks_enabled === (p == ddr3_cmd_pkg::PW_ACTIVE), "clock enable state");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_modes;
    logic [15:0] v [4];
    v = '{16'h0001, 16'h0244, 16'h0A5A, 16'h0003};
    for (int i = 0; i < 4; i++) begin
      run(1'b0, ddr3_cmd_pkg::CMD_LOAD_MODE, 3'(i), v[i], 1'b1, 1'b1);
    end
    chk({mr3_reg, mr2_reg, mr1_reg, mr0_reg} === {v[3], v[2], v[1], v[0]}, "mode regs");
  endtask

  task automatic t_access;
    run(1'b0, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h5, 16'h1234, 1'b1, 1'b1);
    chk(got.bank === 3'h5 && got.row === 16'h1234 && open_banks === 8'h20, "activate");
    run(1'b0, ddr3_cmd_pkg::CMD_READ, 3'h5, 16'h0155, 1'b1, 1'b1);
    chk(got.col === 10'h155 && got.auto_pre === 1'b0 && got.chop4 === 1'b1, "read");
    run(1'b0, ddr3_cmd_pkg::CMD_WRITE, 3'h5, 16'h1422, 1'b1, 1'b1);
    chk(got.col === 10'h022 && got.auto_pre === 1'b1 && got.chop4 === 1'b0 &&
        open_banks === 8'h00, "write");
  endtask

  task automatic t_select;
    run(1'b0, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h2, 16'h0010, 1'b1, 1'b1);
    run(1'b0, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h6, 16'h0020, 1'b1, 1'b1);
    run(1'b1, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h1, 16'h0030, 1'b1, 1'b0);
    run(1'b0, ddr3_cmd_pkg::CMD_PRECHARGE, 3'h2, 16'h0000, 1'b1, 1'b1);
    chk(got.pre_mask === 8'h04 && open_banks === 8'h40, "one bank closed");
    run(1'b0, ddr3_cmd_pkg::CMD_PRECHARGE, 3'h0, 16'h0400, 1'b1, 1'b1);
    chk(got.pre_mask === 8'hFF && open_banks === 8'h00, "all banks closed");
  endtask

  task automatic t_power;
    run(1'b0, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h1, 16'h0040, 1'b1, 1'b1);
    ctrl.set_ctl(1'b0, 1'b0);
    wait_pwr(ddr3_cmd_pkg::PW_POWERDOWN);
    run(1'b0, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h3, 16'h0050, 1'b0, 1'b0);
    chk(open_banks === 8'h02, "active power-down");
    ctrl.set_ctl(1'b1, 1'b0);
    wait_pwr(ddr3_cmd_pkg::PW_ACTIVE);
    run(1'b0, ddr3_cmd_pkg::CMD_PRECHARGE, 3'h0, 16'h0400, 1'b1, 1'b1);
    run(1'b0, ddr3_cmd_pkg::CMD_REFRESH, 3'h0, 16'h0000, 1'b0, 1'b0);
    wait_pwr(ddr3_cmd_pkg::PW_SELFREF);
    ctrl.set_ctl(1'b1, 1'b0);
    wait_pwr(ddr3_cmd_pkg::PW_ACTIVE);
  endtask

  task automatic t_mask;
    int hits;
    logic [7:0] last;
    hits = 0;
    @(posedge clk);
    wbeat_pin <= 1'b1;
    wdata_pin <= 8'hA5;
    @(posedge clk);
    dm_pin <= 1'b1;
    wdata_pin <= 8'h3C;
    @(posedge clk);
    wbeat_pin <= 1'b0;
    dm_pin <= 1'b0;
    wdata_pin <= 8'hC3;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (wbeat_out.valid === 1'b1) begin
        hits++;
        last = wbeat_out.data;
      end
    end
    chk(hits == 1 && last === 8'hA5, "masked beat");
  endtask

  task automatic t_odt;
    ctrl.set_ctl(1'b1, 1'b1);
    for (int i = 0; i < 8 && odt_active !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(odt_active === 1'b1, "termination on");
    run(1'b0, ddr3_cmd_pkg::CMD_LOAD_MODE, 3'h1, 16'h0000, 1'b1, 1'b1);
    chk(odt_active === 1'b0, "termination pin ignored");
    ctrl.set_ctl(1'b1, 1'b0);
  endtask

  task automatic t_reset;
    run(1'b0, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h7, 16'h0070, 1'b1, 1'b1);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(open_banks === 8'h00 && mr0_reg === 16'h0000, "reset pin");
    @(posedge clk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    run(1'b0, ddr3_cmd_pkg::CMD_ACTIVATE, 3'h4, 16'h0080, 1'b1, 1'b1);
    chk(open_banks === 8'h10, "after reset");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_modes();
    t_access();
    t_select();
    t_power();
    t_mask();
    t_odt();
    t_reset();
    final_report();
  end

  // hang guard
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule

bind ddr3_cmd_pin_if ddr3_cmd_pin_monitor mon (.clk(clk), .srst(srst),
  .reset_pin_n(reset_pin_n), .ca_pins(ca_pins), .dm_pin(dm_pin), .wdata_pin(wdata_pin),
  .cmd_out(cmd_out), .open_banks(open_banks), .pwr_state(pwr_state), .odt_active(odt_active),
  .tdqs_enabled(tdqs_enabled), .wbeat_out(wbeat_out), .mr0_reg(mr0_reg), .mr1_reg(mr1_reg));
